// ===== design/irq_flags_pkg.sv
// Package: register map, field positions, reset values and carriers
// for the peripheral interrupt flag block.
// Assumes a 32-bit APB register bus; registers are 8 bits, low lane.
package irq_flags_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_CORE_CTRL = 12'h000;
  localparam logic [11:0] OFS_ENABLE_1 = 12'h004;
  localparam logic [11:0] OFS_ENABLE_2 = 12'h008;
  localparam logic [11:0] OFS_ENABLE_3 = 12'h00C;
  localparam logic [11:0] OFS_FLAGS_1 = 12'h010;
  localparam logic [11:0] OFS_FLAGS_2 = 12'h014;
  localparam logic [11:0] OFS_FLAGS_3 = 12'h018;

  // ****************************************
  // Writable and implemented bit masks
  // ****************************************
  localparam logic [7:0] MASK_CORE_W = 8'hFE;
  localparam logic [7:0] MASK_ENABLE_1 = 8'hFF;
  localparam logic [7:0] MASK_ENABLE_2 = 8'hEF;
  localparam logic [7:0] MASK_ENABLE_3 = 8'h37;
  localparam logic [7:0] MASK_FLAGS_1_W = 8'hCF;
  localparam logic [7:0] MASK_FLAGS_1 = 8'hFF;
  localparam logic [7:0] MASK_FLAGS_2 = 8'hEF;
  localparam logic [7:0] MASK_FLAGS_3 = 8'h37;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_REG = 8'h00;

  // ****************************************
  // Core control field positions
  // ****************************************
  localparam int POS_GLOBAL_EN = 7;
  localparam int POS_GROUP_EN = 6;
  localparam int POS_TMR0_EN = 5;
  localparam int POS_EXT_EN = 4;
  localparam int POS_CHG_EN = 3;
  localparam int POS_TMR0_FLAG = 2;
  localparam int POS_EXT_FLAG = 1;
  localparam int POS_CHG_FLAG = 0;

  // ****************************************
  // Flag register 1 field positions
  // ****************************************
  localparam int POS_RX_FLAG = 5;
  localparam int POS_TX_FLAG = 4;

  // Peripheral event bundle, one bit per flag position
  typedef struct packed {
    logic [7:0] grp1;
    logic [7:0] grp2;
    logic [7:0] grp3;
  } periph_events_t;

  // Core-side event bundle
  typedef struct packed {
    logic tmr0;
    logic ext;
    logic chg;
  } core_events_t;

endpackage

// ===== design/flag_reg8.sv
// Holds one 8-bit sticky flag register.
// Assumes events and writes arrive on the system clock.
`timescale 1ns/1ps
module flag_reg8 (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Events and software access
  input wire logic [7:0] set_i,
  input wire logic [7:0] impl_i,
  input wire logic [7:0] wmask_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // Stored value
  output logic [7:0] q_o
);

  logic [7:0] q_r;
  logic [7:0] q_nxt;

  // Write first, then events set over it
  always_comb begin
    q_nxt = q_r;
    if (wr_i) begin
      q_nxt = (q_r & ~wmask_i) | (wdata_i & wmask_i);
    end
    q_nxt = (q_nxt | set_i) & impl_i;
  end

  // Flags clear on reset
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_r <= irq_flags_pkg::RST_REG;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule

// ===== design/sync2.sv
// Two-flop synchroniser for a bundle of levels.
// Assumes inputs are asynchronous to clk_sys_i.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage read only by second
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule

// ===== design/periph_irq_flags.sv
// Peripheral interrupt enable and request registers with APB access.
// Registers are one byte each, in the low lane of the data bus.
// Assumes event inputs are pin-level and asynchronous; the serial
// receive/transmit flags stay set until reset.
//
// How it works
// - Flags set on events regardless of enables
// - Peripheral requests need group enable set
// - Enable 3 bits five, four, two-zero
// - Enable one allows, zero blocks source
// - Flag register 1 holds eight peripheral flags
// - Serial rx/tx flags are read-only
// - Flag register 2 layout, bit four unused
// - Flag register 3 layout, bits 7,6,3 unused
// - Flag reads one while interrupt pending
// - All implemented bits reset to zero
// - Unimplemented bits read zero, ignore writes
// - Global enable gates every interrupt
// - Enable register 1 mirrors flag register 1
// - Enable register 2 mirrors flag register 2
`timescale 1ns/1ps
module periph_irq_flags (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Interrupt sources, one-cycle or level pulses
  input wire irq_flags_pkg::periph_events_t periph_evt_i,
  input wire irq_flags_pkg::core_events_t core_evt_i,
  // Request to the core
  output logic core_irq_o
);

  // ****************************************
  // Source synchronisation and edge detect
  // ****************************************
  // Width of all event lines, peripheral then core
  localparam int NEV = 27;
  logic [NEV-1:0] evt_raw;
  logic [NEV-1:0] evt_sync;
  logic [NEV-1:0] evt_last_r;
  logic [NEV-1:0] evt_rise;
  irq_flags_pkg::periph_events_t pev;
  irq_flags_pkg::core_events_t cev;

  assign evt_raw = {periph_evt_i, core_evt_i};

  // Two flops on every line; pulses under one clock may be lost
  sync2 #(.W(NEV)) u_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .d_i(evt_raw),
    .q_o(evt_sync)
  );

  // Remember last synchronised level
  // Reset low matches the idle level of every line, so no false edge
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_last_r <= '0;
    end else begin
      evt_last_r <= evt_sync;
    end
  end

  // Rising edge marks a condition. A line held high sets its flag
  // once only: clearing the flag while the line stays high does not
  // set it again until the line falls and rises.
  assign evt_rise = evt_sync & ~evt_last_r;
  assign pev = irq_flags_pkg::periph_events_t'(evt_rise[NEV-1:3]);
  assign cev = irq_flags_pkg::core_events_t'(evt_rise[2:0]);

  // ****************************************
  // APB decode
  // ****************************************
  logic setup_ph;
  logic access_ph;
  logic pready_r;
  logic wr_en;
  logic hit;
  logic wr_core;
  logic wr_en1;
  logic wr_en2;
  logic wr_en3;
  logic wr_fl1;
  logic wr_fl2;
  logic wr_fl3;
  logic [7:0] wbyte;

  // Bus phases; an access ends when ready is high
  assign setup_ph = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i & pready_r;
  // Low lane strobe needed to write
  assign wr_en = access_ph & pwrite_i & pstrb_i[0];
  assign wbyte = pwdata_i[7:0];

  // Ready rises after reset; every access then ends in one cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
    end
  end

  // Address match
  // Only aligned offsets of the seven registers hit
  always_comb begin
    hit = 1'b1;
    unique case (paddr_i)
      irq_flags_pkg::OFS_CORE_CTRL,
      irq_flags_pkg::OFS_ENABLE_1,
      irq_flags_pkg::OFS_ENABLE_2,
      irq_flags_pkg::OFS_ENABLE_3,
      irq_flags_pkg::OFS_FLAGS_1,
      irq_flags_pkg::OFS_FLAGS_2,
      irq_flags_pkg::OFS_FLAGS_3: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // One write strobe per register
  assign wr_core = wr_en & (paddr_i == irq_flags_pkg::OFS_CORE_CTRL);
  assign wr_en1 = wr_en & (paddr_i == irq_flags_pkg::OFS_ENABLE_1);
  assign wr_en2 = wr_en & (paddr_i == irq_flags_pkg::OFS_ENABLE_2);
  assign wr_en3 = wr_en & (paddr_i == irq_flags_pkg::OFS_ENABLE_3);
  assign wr_fl1 = wr_en & (paddr_i == irq_flags_pkg::OFS_FLAGS_1);
  assign wr_fl2 = wr_en & (paddr_i == irq_flags_pkg::OFS_FLAGS_2);
  assign wr_fl3 = wr_en & (paddr_i == irq_flags_pkg::OFS_FLAGS_3);

  // ****************************************
  // Enable registers
  // ****************************************
  logic [7:0] enable_1_r;
  logic [7:0] enable_2_r;
  logic [7:0] enable_3_r;
  logic [7:0] core_ctrl_r;

  // Enable register 1, all eight bits writable
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_1_r <= irq_flags_pkg::RST_REG;
    end else if (wr_en1) begin
      enable_1_r <= wbyte & irq_flags_pkg::MASK_ENABLE_1;
    end
  end

  // Enable register 2, bit four held zero
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_2_r <= irq_flags_pkg::RST_REG;
    end else if (wr_en2) begin
      enable_2_r <= wbyte & irq_flags_pkg::MASK_ENABLE_2;
    end
  end

  // Enable register 3, bits seven, six and three held zero
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_3_r <= irq_flags_pkg::RST_REG;
    end else if (wr_en3) begin
      enable_3_r <= wbyte & irq_flags_pkg::MASK_ENABLE_3;
    end
  end

  // ****************************************
  // Core control register
  // ****************************************
  logic [7:0] core_nxt;

  // Writable enables and flags; events set over writes
  // An event in the same cycle as a clearing write leaves the flag
  // set, so no condition is lost to a read-modify-write race
  always_comb begin
    core_nxt = core_ctrl_r;
    if (wr_core) begin
      core_nxt = (core_ctrl_r & ~irq_flags_pkg::MASK_CORE_W)
               | (wbyte & irq_flags_pkg::MASK_CORE_W);
    end
    core_nxt[irq_flags_pkg::POS_TMR0_FLAG] = core_nxt[irq_flags_pkg::POS_TMR0_FLAG] | cev.tmr0;
    core_nxt[irq_flags_pkg::POS_EXT_FLAG] = core_nxt[irq_flags_pkg::POS_EXT_FLAG] | cev.ext;
    // Change flag is a plain sticky bit here, software-cleared by writing zero to it via core control write
    core_nxt[irq_flags_pkg::POS_CHG_FLAG] = core_ctrl_r[irq_flags_pkg::POS_CHG_FLAG] | cev.chg;
    if (wr_core && !wbyte[irq_flags_pkg::POS_CHG_FLAG] && !cev.chg) begin
      core_nxt[irq_flags_pkg::POS_CHG_FLAG] = 1'b0;
    end
  end

  // Core control storage
  // Enables and flags clear on every reset
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_ctrl_r <= irq_flags_pkg::RST_REG;
    end else begin
      core_ctrl_r <= core_nxt;
    end
  end

  // ****************************************
  // Flag registers
  // ****************************************
  logic [7:0] flags_1;
  logic [7:0] flags_2;
  logic [7:0] flags_3;

  // Flag register 1; serial rx/tx not software-writable
  // Serial rx/tx clear only on reset, as their sources own them
  flag_reg8 u_flags_1 (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .set_i(pev.grp1),
    .impl_i(irq_flags_pkg::MASK_FLAGS_1),
    .wmask_i(irq_flags_pkg::MASK_FLAGS_1_W),
    .wr_i(wr_fl1),
    .wdata_i(wbyte),
    .q_o(flags_1)
  );

  // Flag register 2
  flag_reg8 u_flags_2 (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .set_i(pev.grp2),
    .impl_i(irq_flags_pkg::MASK_FLAGS_2),
    .wmask_i(irq_flags_pkg::MASK_FLAGS_2),
    .wr_i(wr_fl2),
    .wdata_i(wbyte),
    .q_o(flags_2)
  );

  // Flag register 3
  flag_reg8 u_flags_3 (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .set_i(pev.grp3),
    .impl_i(irq_flags_pkg::MASK_FLAGS_3),
    .wmask_i(irq_flags_pkg::MASK_FLAGS_3),
    .wr_i(wr_fl3),
    .wdata_i(wbyte),
    .q_o(flags_3)
  );

  // ****************************************
  // Request to the core
  // ****************************************
  logic global_irq_enable;
  logic periph_group_enable;
  logic pend_1;
  logic pend_2;
  logic pend_3;
  logic tmr0_pend;
  logic ext_pend;
  logic chg_pend;
  logic periph_pending;
  logic core_pending;
  logic irq_r;

  assign global_irq_enable = core_ctrl_r[irq_flags_pkg::POS_GLOBAL_EN];
  assign periph_group_enable = core_ctrl_r[irq_flags_pkg::POS_GROUP_EN];

  // Per register, some flag with its enable set
  assign pend_1 = |(flags_1 & enable_1_r);
  assign pend_2 = |(flags_2 & enable_2_r);
  assign pend_3 = |(flags_3 & enable_3_r);
  // Group enable gates every peripheral source
  assign periph_pending = periph_group_enable & (pend_1 | pend_2 | pend_3);
  // Core sources need no group enable
  assign tmr0_pend = core_ctrl_r[irq_flags_pkg::POS_TMR0_EN]
    & core_ctrl_r[irq_flags_pkg::POS_TMR0_FLAG];
  assign ext_pend = core_ctrl_r[irq_flags_pkg::POS_EXT_EN]
    & core_ctrl_r[irq_flags_pkg::POS_EXT_FLAG];
  assign chg_pend = core_ctrl_r[irq_flags_pkg::POS_CHG_EN]
    & core_ctrl_r[irq_flags_pkg::POS_CHG_FLAG];
  assign core_pending = tmr0_pend | ext_pend | chg_pend;

  // Registered request
  // A glitch-free level for the core, at the cost of one cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= global_irq_enable & (core_pending | periph_pending);
    end
  end

  assign core_irq_o = irq_r;

  // ****************************************
  // APB read path
  // ****************************************
  logic [7:0] rd_byte;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // Read mux; flags read one while pending
  always_comb begin
    rd_byte = 8'h00;
    unique case (paddr_i)
      irq_flags_pkg::OFS_CORE_CTRL: rd_byte = core_ctrl_r;
      irq_flags_pkg::OFS_ENABLE_1: rd_byte = enable_1_r;
      irq_flags_pkg::OFS_ENABLE_2: rd_byte = enable_2_r;
      irq_flags_pkg::OFS_ENABLE_3: rd_byte = enable_3_r;
      irq_flags_pkg::OFS_FLAGS_1: rd_byte = flags_1;
      irq_flags_pkg::OFS_FLAGS_2: rd_byte = flags_2;
      irq_flags_pkg::OFS_FLAGS_3: rd_byte = flags_3;
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data taken at the setup edge so it stands settled through
  // the access phase; a flag set during that phase shows next read
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_r <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
  end

  // Unmapped or unaligned address answers with an error
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      pslverr_r <= ~hit;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;

endmodule

// ===== testbench/irq_flags_chk.sv
// Checker: port-level properties of the interrupt flag block.
// Assumes it is bound to every periph_irq_flags instance.
`timescale 1ns/1ps
module irq_flags_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Request
  input wire logic core_irq_o
);
  // ****
  // Helpers
  // ****
  logic gie_r;
  logic acc;
  logic rd;
  // Access phase and read qualifiers
  assign acc = psel_i && penable_i && pready_o;
  assign rd = acc && !pwrite_i;
  // Shadow of the global enable
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gie_r <= 1'b0;
    end else if (acc && pwrite_i && pstrb_i[0] && paddr_i == 12'h000) begin
      gie_r <= pwdata_i[7];
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // ****
  // Properties
  // ****
  upper_zero_a: assert property (acc |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_err_a: assert property (acc && paddr_i > 12'h018 |-> pslverr_o && prdata_o == 0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && paddr_i <= 12'h018 && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
    else $error("mapped access refused");
  en3_gap_a: assert property (rd && paddr_i == 12'h00C |-> (prdata_o[7:0] & 8'hC8) == 0)
    else $error("enable 3 gap bits set");
  fl3_gap_a: assert property (rd && paddr_i == 12'h018 |-> (prdata_o[7:0] & 8'hC8) == 0)
    else $error("flags 3 gap bits set");
  en2_gap_a: assert property (rd && paddr_i == 12'h008 |-> !prdata_o[4])
    else $error("enable 2 bit four set");
  fl2_gap_a: assert property (rd && paddr_i == 12'h014 |-> !prdata_o[4])
    else $error("flags 2 bit four set");
  gie_block_a: assert property (!gie_r && !$past(gie_r) |-> !core_irq_o)
    else $error("request without global enable");
  irq_needs_gie_a: assert property ($rose(core_irq_o) |-> $past(gie_r))
    else $error("request rose without global enable");
  reset_clear_a: assert property ($rose(resetn_i) |-> !core_irq_o && prdata_o == 0)
    else $error("outputs not clear after reset");
endmodule

bind periph_irq_flags irq_flags_chk irq_flags_chk_inst (.clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .core_irq_o(core_irq_o));

// ===== testbench/irq_src_model.sv
// Partner: peripheral and core interrupt sources beside the block.
// Assumes fire_i is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module irq_src_model (
  // Clock
  input wire logic clk_sys_i,
  // Control from the bench
  input wire logic fire_i,
  input wire irq_flags_pkg::periph_events_t pmask_i,
  input wire irq_flags_pkg::core_events_t cmask_i,
  // Event lines
  output irq_flags_pkg::periph_events_t periph_evt_o,
  output irq_flags_pkg::core_events_t core_evt_o
);
  logic [2:0] hold_r = 3'h0;
  // Hold selected lines high four cycles, long enough to sync
  always_ff @(posedge clk_sys_i) begin
    if (fire_i) begin
      hold_r <= 3'h4;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end
  end
  // Lines low between events
  assign periph_evt_o = (hold_r != 3'h0) ? pmask_i : '0;
  assign core_evt_o = (hold_r != 3'h0) ? cmask_i : '0;
endmodule

// ===== testbench/periph_irq_flags_tb.sv
// Bench: register, event and request checks of periph_irq_flags.
// Assumes the partner model drives every event line.
`timescale 1ns/1ps
module periph_irq_flags_tb;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic core_irq;
  logic fire = 1'b0;
  logic [23:0] pmask = 24'hFFFFFF;
  logic [2:0] cmask = 3'h7;
  irq_flags_pkg::periph_events_t pev;
  irq_flags_pkg::core_events_t cev;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rd_v;
  logic err_v;
  // Visible bits per register index, core control unused
  logic [7:0] wm [7] = '{8'h00, 8'hFF, 8'hEF, 8'h37, 8'hCF, 8'hEF, 8'h37};

  // ****
  // Clock, instances, timeout
  // ****
  always #4 clk_sys_i = ~clk_sys_i;
  irq_src_model irq_src_model_inst (.clk_sys_i(clk_sys_i), .fire_i(fire),
    .pmask_i(pmask), .cmask_i(cmask), .periph_evt_o(pev), .core_evt_o(cev));
  periph_irq_flags periph_irq_flags_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .periph_evt_i(pev), .core_evt_i(cev), .core_irq_o(core_irq));
  // Cut a hang short
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end

  // ****
  // Shared tasks
  // ****
  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // One APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, rd_v, e);
  endtask
  task automatic irq(input logic e, input string nm);
    repeat (2) @(posedge clk_sys_i);
    chk(nm, {31'h0, core_irq}, {31'h0, e});
  endtask
  task automatic fire_evt(input logic [23:0] p, input logic [2:0] c);
    pmask <= p;
    cmask <= c;
    fire <= 1'b1;
    @(posedge clk_sys_i);
    fire <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    for (int a = 0; a < 28; a += 4) begin
      rd(12'(a), 32'h0, "reset value");
    end
    apb(1'b0, 12'h01C, 8'h00);
    chk("unmapped err", {31'h0, err_v}, 32'h1);
    chk("unmapped data", rd_v, 32'h0);
  endtask
  task automatic t_masks();
    for (int i = 1; i < 7; i++) begin
      wr(12'(4 * i), 8'hFF);
      rd(12'(4 * i), {24'h0, wm[i]}, "ones");
      wr(12'(4 * i), 8'h00);
      rd(12'(4 * i), 32'h0, "zeros");
    end
  endtask
  task automatic t_events();
    fire_evt({8'h0E, 8'h9C, 8'hF1}, 3'h6);
    rd(12'h010, 32'h00E, "flags1 pos");
    rd(12'h014, 32'h08C, "flags2 pos");
    rd(12'h018, 32'h031, "flags3 pos");
    rd(12'h000, 32'h006, "core pos");
    wr(12'h010, 8'h00);
    wr(12'h014, 8'h00);
    wr(12'h018, 8'h00);
    wr(12'h000, 8'h00);
    fire_evt(24'hFFFFFF, 3'h7);
    rd(12'h010, 32'h0FF, "flags1 evt");
    rd(12'h014, 32'h0EF, "flags2 evt");
    rd(12'h018, 32'h037, "flags3 evt");
    rd(12'h000, 32'h007, "core evt");
    irq(1'b0, "no global");
  endtask
  task automatic t_gating();
    wr(12'h000, 8'h80);
    wr(12'h00C, 8'h01);
    irq(1'b0, "no group");
    wr(12'h00C, 8'h00);
    wr(12'h000, 8'hC0);
    for (int i = 1; i < 4; i++) begin
      for (int b = 0; b < 8; b++) begin
        if (wm[i][b]) begin
          wr(12'(4 * i), 8'(1 << b));
          irq(1'b1, "enable one");
          wr(12'(4 * i), 8'h00);
          irq(1'b0, "enable zero");
        end
      end
    end
  endtask
  task automatic t_clear_first();
    wr(12'h010, 8'h00);
    rd(12'h010, 32'h030, "rx tx kept");
    wr(12'h014, 8'h00);
    wr(12'h018, 8'h00);
    wr(12'h004, 8'hCF);
    wr(12'h008, 8'hEF);
    wr(12'h00C, 8'h37);
    irq(1'b0, "cleared");
    fire_evt(24'hFFFFFF, 3'h7);
    irq(1'b1, "new event");
    wr(12'h004, 8'h00);
    wr(12'h008, 8'h00);
    wr(12'h00C, 8'h00);
    irq(1'b0, "enables off");
    wr(12'h000, 8'hA6);
    irq(1'b1, "core source");
    wr(12'h000, 8'h00);
    irq(1'b0, "global off");
  endtask
  task automatic t_rerst();
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(12'h010, 32'h0, "flags1 rerst");
    rd(12'h004, 32'h0, "enable1 rerst");
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_masks();
    t_events();
    t_gating();
    t_clear_first();
    t_rerst();
    end_sim();
  end
endmodule
